// ### sest_pkg.sv
// Constants, register map and carrier types of the status event summary tree.
// Assumes one 10 MHz clock and a synchronous active-high reset standing for power-up.
package sest_pkg;
   localparam int REG_W  = 16;
   localparam int ADDR_W = 6;
   localparam int ERR_CNT_W = 6;
   // Register addresses
   localparam logic [5:0] A_STB      = 6'h00;
   localparam logic [5:0] A_SRE      = 6'h01;
   localparam logic [5:0] A_ESR      = 6'h02;
   localparam logic [5:0] A_ESE      = 6'h03;
   localparam logic [5:0] A_CMD      = 6'h04;
   localparam logic [5:0] A_IRQ_STAT = 6'h05;
   localparam logic [5:0] A_IRQ_CLR  = 6'h06;
   localparam logic [5:0] A_IRQ_EN   = 6'h07;
   localparam logic [5:0] A_ERR_CNT  = 6'h08;
   // Branch block: base + 6*branch + 2*level + (0 event, 1 enable)
   localparam logic [5:0] A_BR_BASE  = 6'h10;
   localparam logic [5:0] A_BR_SPAN  = 6'h06;
   localparam int NUM_BR = 3;
   localparam int BR_QUES = 0;
   localparam int BR_OPER = 1;
   localparam int BR_MEAS = 2;
   // Command register bits
   localparam int CMD_CLS     = 0;
   localparam int CMD_ERR_POP = 1;
   // Status byte bit positions
   localparam int SB_MEAS  = 0;
   localparam int SB_ERR   = 2;
   localparam int SB_QUES  = 3;
   localparam int SB_REPLY = 4;
   localparam int SB_STD   = 5;
   localparam int SB_RQS   = 6;
   localparam int SB_OPER  = 7;
   // Chain feed positions
   localparam int INSTRUMENT_BRANCH_SUMMARY_BIT = 13;
   localparam int SUM_IN_BIT = 1;
   localparam logic [15:0] ZERO16 = 16'h0000;
   localparam logic [7:0]  ZERO8  = 8'h00;
   localparam logic [15:0] MSB_EXCL_RQS = 16'h00BF;
   // Interrupt status bits
   localparam int IRQ_RQS = 0;
   localparam int IRQ_ERR = 1;
   localparam int IRQ_OVF = 2;
   localparam int IRQ_W   = 3;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [REG_W-1:0]  wdata;
      logic              wr;
      logic              rd;
   } sest_bus_t;

   typedef struct packed {
      logic [REG_W-1:0] sum_cond;
      logic [REG_W-1:0] inst_cond;
      logic [REG_W-1:0] top_cond;
   } sest_branch_cond_t;
endpackage

// ### sest_event_reg.sv
// One event register with its enable register and summary output.
// Assumes conditions come from logic on the same clock.
`timescale 1ns/1ps
module sest_event_reg #(
   parameter int WIDTH = 16
) (
   input  wire logic             clk_in,
   input  wire logic             rst_in,
   input  wire logic [WIDTH-1:0] cond_in,
   input  wire logic             clear_in,
   input  wire logic             read_in,
   input  wire logic             en_wr_in,
   input  wire logic [WIDTH-1:0] en_data_in,
   output logic      [WIDTH-1:0] event_out,
   output logic      [WIDTH-1:0] enable_out,
   output logic                  summary_out
);
   // Elaboration check: the logic serves one to sixteen bits
   if (WIDTH < 1 || WIDTH > 16) begin : g_bad_width
      $error("sest_event_reg: bad WIDTH");
   end

   logic [WIDTH-1:0] cond_q;
   logic [WIDTH-1:0] rise;

   always_ff @(posedge clk_in) begin
      if (rst_in) cond_q <= '0;
      else cond_q <= cond_in;
   end

   assign rise = cond_in & ~cond_q;

   // Latch on rise; read or clear drops bits but a new rise wins
   always_ff @(posedge clk_in) begin
      if (rst_in) event_out <= '0;
      else if (clear_in || read_in) event_out <= rise;
      else event_out <= event_out | rise;
   end

   // Whole-word replacement, zero write clears all
   always_ff @(posedge clk_in) begin
      if (rst_in) enable_out <= '0;
      else if (en_wr_in) enable_out <= en_data_in;
   end

   assign summary_out = |(event_out & enable_out);

   stale_hidden_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (enable_out == '0) |-> !summary_out)
      else $error("summary set with no enable");
   en_whole_a: assert property (@(posedge clk_in) disable iff (rst_in)
      en_wr_in |=> (enable_out == $past(en_data_in)))
      else $error("enable not replaced whole");
   rise_latch_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (rise != '0) |=> ((event_out & $past(rise)) == $past(rise)))
      else $error("rising condition not latched");
endmodule

// ### sest_status_byte.sv
// Status byte assembly and request-for-service summary.
// Assumes summary inputs come from logic on the same clock.
`timescale 1ns/1ps
module sest_status_byte (
   input  wire logic       meas_sum_in,
   input  wire logic       ques_sum_in,
   input  wire logic       oper_sum_in,
   input  wire logic       std_sum_in,
   input  wire logic       error_waiting_in,
   input  wire logic       reply_waiting_in,
   input  wire logic [7:0] sre_in,
   output logic      [7:0] stb_out
);
   logic [7:0] sums;

   // Summary bits follow sources, no latch
   always_comb begin
      sums = sest_pkg::ZERO8;
      sums[sest_pkg::SB_MEAS]  = meas_sum_in;
      sums[sest_pkg::SB_ERR]   = error_waiting_in;
      sums[sest_pkg::SB_QUES]  = ques_sum_in;
      sums[sest_pkg::SB_REPLY] = reply_waiting_in;
      sums[sest_pkg::SB_STD]   = std_sum_in;
      sums[sest_pkg::SB_OPER]  = oper_sum_in;
      stb_out = sums;
      stb_out[sest_pkg::SB_RQS] = |(sums & sre_in & sest_pkg::MSB_EXCL_RQS[7:0]);
   end
endmodule

// ### sest_top.sv
// Status event summary tree: standard, questionable, operation and measurement sets,
// error queue count and reply-waiting input, status byte and interrupt. Assumes one clock, plain register port.
`timescale 1ns/1ps
module sest_top #(
   parameter int ERR_DEPTH = 32
) (
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire logic [5:0]  addr_in,
   input  wire logic [15:0] wdata_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   output logic      [15:0] rdata_out,
   input  wire logic [7:0]  std_event_in,
   input  wire logic [15:0] ques_sum_cond_in,
   input  wire logic [15:0] ques_inst_cond_in,
   input  wire logic [15:0] ques_top_cond_in,
   input  wire logic [15:0] oper_sum_cond_in,
   input  wire logic [15:0] oper_inst_cond_in,
   input  wire logic [15:0] oper_top_cond_in,
   input  wire logic [15:0] meas_sum_cond_in,
   input  wire logic [15:0] meas_inst_cond_in,
   input  wire logic [15:0] meas_top_cond_in,
   input  wire logic        err_push_in,
   input  wire logic        reply_waiting_in,
   output logic      [7:0]  stb_out,
   output logic             irq_out
);
   // Elaboration check: the six-bit error counter holds at most 63
   if (ERR_DEPTH < 1 || ERR_DEPTH > 63) begin : g_bad_depth
      $error("sest_top: bad ERR_DEPTH");
   end

   sest_pkg::sest_bus_t         bus;
   sest_pkg::sest_branch_cond_t bc [sest_pkg::NUM_BR];
   logic [15:0] br_ev  [sest_pkg::NUM_BR][3];
   logic [15:0] br_en  [sest_pkg::NUM_BR][3];
   logic        br_sum [sest_pkg::NUM_BR][3];
   logic [7:0]  std_ev;
   logic [7:0]  std_en;
   logic        std_sum;
   logic [7:0]  sre;
   logic [7:0]  stb_now;
   logic [5:0]  err_cnt;
   logic        cls;
   logic        err_pop;
   logic        error_waiting;
   logic [2:0]  irq_stat;
   logic [2:0]  irq_en;
   logic [2:0]  irq_evt;
   logic        rqs_q;
   logic        err_q;
   logic [15:0] next_rdata;

   assign bus.addr  = addr_in;
   assign bus.wdata = wdata_in;
   assign bus.wr    = wr_in;
   assign bus.rd    = rd_in;

   assign bc[sest_pkg::BR_QUES] = '{ques_sum_cond_in, ques_inst_cond_in, ques_top_cond_in};
   assign bc[sest_pkg::BR_OPER] = '{oper_sum_cond_in, oper_inst_cond_in, oper_top_cond_in};
   assign bc[sest_pkg::BR_MEAS] = '{meas_sum_cond_in, meas_inst_cond_in, meas_top_cond_in};

   assign cls     = bus.wr && bus.addr == sest_pkg::A_CMD && bus.wdata[sest_pkg::CMD_CLS];
   assign err_pop = bus.wr && bus.addr == sest_pkg::A_CMD && bus.wdata[sest_pkg::CMD_ERR_POP];

   // Three-level chain per branch; lower summary feeds the level above
   for (genvar b = 0; b < sest_pkg::NUM_BR; b++) begin : g_br
      for (genvar l = 0; l < 3; l++) begin : g_lvl
         localparam logic [5:0] EV_A = 6'(sest_pkg::A_BR_BASE
            + sest_pkg::A_BR_SPAN * b + 2 * l);
         logic [15:0] cond;
         always_comb begin
            cond = (l == 0) ? bc[b].sum_cond : (l == 1) ? bc[b].inst_cond : bc[b].top_cond;
            if (l == 1) cond[sest_pkg::SUM_IN_BIT] = br_sum[b][0];
            if (l == 2) cond[sest_pkg::INSTRUMENT_BRANCH_SUMMARY_BIT] = br_sum[b][1];
         end
         sest_event_reg #(.WIDTH(16)) u_reg (
            .clk_in      (clk_in),
            .rst_in      (rst_in),
            .cond_in     (cond),
            .clear_in    (cls),
            .read_in     (bus.rd && bus.addr == EV_A),
            .en_wr_in    (bus.wr && bus.addr == 6'(EV_A + 1)),
            .en_data_in  (bus.wdata),
            .event_out   (br_ev[b][l]),
            .enable_out  (br_en[b][l]),
            .summary_out (br_sum[b][l])
         );
      end
   end

   sest_event_reg #(.WIDTH(8)) u_std (
      .clk_in      (clk_in),
      .rst_in      (rst_in),
      .cond_in     (std_event_in),
      .clear_in    (cls),
      .read_in     (bus.rd && bus.addr == sest_pkg::A_ESR),
      .en_wr_in    (bus.wr && bus.addr == sest_pkg::A_ESE),
      .en_data_in  (bus.wdata[7:0]),
      .event_out   (std_ev),
      .enable_out  (std_en),
      .summary_out (std_sum)
   );

   // Service request enable, whole byte
   always_ff @(posedge clk_in) begin
      if (rst_in) sre <= sest_pkg::ZERO8;
      else if (bus.wr && bus.addr == sest_pkg::A_SRE) sre <= bus.wdata[7:0];
   end

   // Error queue occupancy; pushes counted, pops by command, cleared by clear-status
   always_ff @(posedge clk_in) begin
      if (rst_in || cls) err_cnt <= '0;
      else if (err_push_in && !(err_pop && err_cnt != '0)) begin
         if (err_cnt != 6'(ERR_DEPTH)) err_cnt <= err_cnt + 6'h01;
      end else if (!err_push_in && err_pop && err_cnt != '0) err_cnt <= err_cnt - 6'h01;
   end
   assign error_waiting = (err_cnt != '0);

   sest_status_byte u_sb (
      .meas_sum_in      (br_sum[sest_pkg::BR_MEAS][2]),
      .ques_sum_in      (br_sum[sest_pkg::BR_QUES][2]),
      .oper_sum_in      (br_sum[sest_pkg::BR_OPER][2]),
      .std_sum_in       (std_sum),
      .error_waiting_in (error_waiting),
      .reply_waiting_in (reply_waiting_in),
      .sre_in           (sre),
      .stb_out          (stb_now)
   );

   always_ff @(posedge clk_in) begin
      if (rst_in) stb_out <= sest_pkg::ZERO8;
      else stb_out <= stb_now;
   end

   // Interrupt events: rising request-for-service, error queue leaving empty, queue full push
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rqs_q <= 1'b0;
         err_q <= 1'b0;
      end else begin
         rqs_q <= stb_now[sest_pkg::SB_RQS];
         err_q <= error_waiting;
      end
   end
   assign irq_evt[sest_pkg::IRQ_RQS] = stb_now[sest_pkg::SB_RQS] && !rqs_q;
   assign irq_evt[sest_pkg::IRQ_ERR] = error_waiting && !err_q;
   assign irq_evt[sest_pkg::IRQ_OVF] = err_push_in && err_cnt == 6'(ERR_DEPTH);

   // Sticky status: set wins over clear
   always_ff @(posedge clk_in) begin
      if (rst_in) irq_stat <= '0;
      else if (bus.wr && bus.addr == sest_pkg::A_IRQ_CLR)
         irq_stat <= (irq_stat & ~bus.wdata[2:0]) | irq_evt;
      else irq_stat <= irq_stat | irq_evt;
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) irq_en <= '0;
      else if (bus.wr && bus.addr == sest_pkg::A_IRQ_EN) irq_en <= bus.wdata[2:0];
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) irq_out <= 1'b0;
      else irq_out <= |(irq_stat & irq_en);
   end

   // Read mux; unmapped and write-only addresses read zero
   always_comb begin
      next_rdata = sest_pkg::ZERO16;
      case (bus.addr)
         sest_pkg::A_STB:      next_rdata = {8'h00, stb_now};
         sest_pkg::A_SRE:      next_rdata = {8'h00, sre};
         sest_pkg::A_ESR:      next_rdata = {8'h00, std_ev};
         sest_pkg::A_ESE:      next_rdata = {8'h00, std_en};
         sest_pkg::A_IRQ_STAT: next_rdata = {13'h0000, irq_stat};
         sest_pkg::A_IRQ_EN:   next_rdata = {13'h0000, irq_en};
         sest_pkg::A_ERR_CNT:  next_rdata = {10'h000, err_cnt};
         default: begin
            for (int b = 0; b < sest_pkg::NUM_BR; b++) begin
               for (int l = 0; l < 3; l++) begin
                  if (bus.addr == 6'(sest_pkg::A_BR_BASE + sest_pkg::A_BR_SPAN * b + 2 * l))
                     next_rdata = br_ev[b][l];
                  if (bus.addr == 6'(sest_pkg::A_BR_BASE + sest_pkg::A_BR_SPAN * b + 2 * l + 1))
                     next_rdata = br_en[b][l];
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) rdata_out <= sest_pkg::ZERO16;
      else if (bus.rd) rdata_out <= next_rdata;
      else rdata_out <= sest_pkg::ZERO16;
   end

   rqs_follow_a: assert property (@(posedge clk_in) disable iff (rst_in)
      ##1 stb_out[sest_pkg::SB_RQS] == |($past(stb_now) & $past(sre) & 8'hBF))
      else $error("request bit mismatch");
   err_bit_a: assert property (@(posedge clk_in) disable iff (rst_in)
      ##1 stb_out[sest_pkg::SB_ERR] == ($past(err_cnt) != 6'h00))
      else $error("error bit wrong");
   reply_bit_a: assert property (@(posedge clk_in) disable iff (rst_in)
      reply_waiting_in |=> stb_out[sest_pkg::SB_REPLY])
      else $error("reply bit missing");
   cls_clears_a: assert property (@(posedge clk_in) disable iff (rst_in)
      cls && !err_push_in |=> err_cnt == 6'h00)
      else $error("clear-status left errors");
   sre_zero_a: assert property (@(posedge clk_in) disable iff (rst_in)
      bus.wr && bus.addr == sest_pkg::A_SRE && bus.wdata[7:0] == 8'h00 |=> sre == 8'h00)
      else $error("zero write did not clear");
   std_mask_a: assert property (@(posedge clk_in) disable iff (rst_in)
      std_en == 8'h00 |-> !stb_now[sest_pkg::SB_STD])
      else $error("masked standard event shows");
   read_data_a: assert property (@(posedge clk_in) disable iff (rst_in)
      bus.rd && bus.addr == sest_pkg::A_SRE |=> rdata_out == {8'h00, $past(sre)})
      else $error("read data wrong");
   power_up_a: assert property (@(posedge clk_in)
      rst_in |=> stb_out == 8'h00 && sre == 8'h00 && err_cnt == 6'h00)
      else $error("state not cleared at reset");
endmodule

// ### sest_top_bench.sv
// Self-checking bench for the status event summary tree top level.
// Assumes sest_pkg and the design files are compiled first; one 10 MHz clock.
`timescale 1ns/1ps
module sest_top_bench;
   typedef struct packed {
      logic [5:0]  ev_addr;
      logic [15:0] cond;
      logic [15:0] en;
      logic [7:0]  sre;
      logic [7:0]  stb;
   } sest_row_t;
   logic        clk_in           = 1'b0;
   logic        rst_in           = 1'b1;
   logic [5:0]  addr_in          = 6'h00;
   logic [15:0] wdata_in         = 16'h0000;
   logic        wr_in            = 1'b0;
   logic        rd_in            = 1'b0;
   logic [7:0]  std_event_in     = 8'h00;
   logic [15:0] cond [9]         = '{default: 16'h0000};
   logic        err_push_in      = 1'b0;
   logic        reply_waiting_in = 1'b0;
   logic [15:0] rdata_out;
   logic [7:0]  stb_out;
   logic        irq_out;
   int          fail_count       = 0;
   int          total_checks     = 0;
   logic [7:0]  chain_stb [3]    = '{8'h08, 8'h80, 8'h01};
   sest_row_t   rows [7]         = '{
      '{6'h02, 16'h0009, 16'h0009, 8'h20, 8'h60},
      '{6'h02, 16'h0009, 16'h0000, 8'h20, 8'h00},
      '{6'h14, 16'h0004, 16'h0004, 8'h08, 8'h48},
      '{6'h1A, 16'h8000, 16'h8000, 8'h00, 8'h80},
      '{6'h20, 16'h0001, 16'h0001, 8'h01, 8'h41},
      '{6'h14, 16'h00F0, 16'h0F00, 8'hFF, 8'h00},
      '{6'h20, 16'h0100, 16'hFFFF, 8'h80, 8'h01}};

   sest_top #(.ERR_DEPTH(4)) i_sest_top (
      .clk_in            (clk_in),
      .rst_in            (rst_in),
      .addr_in           (addr_in),
      .wdata_in          (wdata_in),
      .wr_in             (wr_in),
      .rd_in             (rd_in),
      .rdata_out         (rdata_out),
      .std_event_in      (std_event_in),
      .ques_sum_cond_in  (cond[0]),
      .ques_inst_cond_in (cond[1]),
      .ques_top_cond_in  (cond[2]),
      .oper_sum_cond_in  (cond[3]),
      .oper_inst_cond_in (cond[4]),
      .oper_top_cond_in  (cond[5]),
      .meas_sum_cond_in  (cond[6]),
      .meas_inst_cond_in (cond[7]),
      .meas_top_cond_in  (cond[8]),
      .err_push_in       (err_push_in),
      .reply_waiting_in  (reply_waiting_in),
      .stb_out           (stb_out),
      .irq_out           (irq_out)
   );

   initial begin
      forever #50 clk_in = ~clk_in;
   end

   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wait_n(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask

   task automatic bus_wr(input logic [5:0] a, input logic [15:0] d);
      @(posedge clk_in);
      addr_in  <= a;
      wdata_in <= d;
      wr_in    <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd_chk(input string name, input logic [5:0] a, input logic [15:0] exp);
      @(posedge clk_in);
      addr_in <= a;
      rd_in   <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1;
      chk(name, rdata_out, exp);
   endtask

   task automatic cond_set(input logic [5:0] a, input logic [15:0] v);
      @(posedge clk_in);
      if (a == sest_pkg::A_ESR) begin
         std_event_in <= v[7:0];
      end else begin
         cond[int'(a - sest_pkg::A_BR_BASE) / 2] <= v;
      end
   endtask

   task automatic push(input int n);
      repeat (n) begin
         @(posedge clk_in);
         err_push_in <= 1'b1;
         @(posedge clk_in);
         err_push_in <= 1'b0;
      end
   endtask

   task automatic do_reset();
      @(posedge clk_in);
      rst_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      rst_in <= 1'b0;
      wait_n(1);
   endtask

   initial begin
      #3000000;
      fail_count++;
      summarize();
   end

   initial begin
      do_reset();
      chk("stb_out", {8'h00, stb_out}, 16'h0000);
      chk("irq_out", {15'h0000, irq_out}, 16'h0000);
      for (int a = 0; a < 64; a++) begin
         rd_chk("reset_reg", 6'(a), 16'h0000);
      end
      // Masking and summary table
      foreach (rows[i]) begin
         bus_wr(rows[i].ev_addr + 6'h01, rows[i].en);
         bus_wr(sest_pkg::A_SRE, {8'h00, rows[i].sre});
         cond_set(rows[i].ev_addr, rows[i].cond);
         wait_n(4);
         chk("stb_row", {8'h00, stb_out}, {8'h00, rows[i].stb});
         rd_chk("stb_reg", sest_pkg::A_STB, {8'h00, rows[i].stb});
         cond_set(rows[i].ev_addr, 16'h0000);
         rd_chk("event", rows[i].ev_addr, rows[i].cond);
         rd_chk("event_clr", rows[i].ev_addr, 16'h0000);
         wait_n(3);
         chk("stb_drop", {8'h00, stb_out}, 16'h0000);
         bus_wr(rows[i].ev_addr + 6'h01, 16'h0000);
         rd_chk("en_zero", rows[i].ev_addr + 6'h01, 16'h0000);
      end
      bus_wr(sest_pkg::A_SRE, 16'h0000);
      bus_wr(sest_pkg::A_IRQ_CLR, 16'h0007);
      // Three level chains
      for (int b = 0; b < 3; b++) begin
         logic [5:0] base;
         base = 6'(16 + 6 * b);
         bus_wr(base + 6'h01, 16'h0001);
         bus_wr(base + 6'h03, 16'h0002);
         bus_wr(base + 6'h05, 16'h2000);
         cond_set(base, 16'h0001);
         wait_n(8);
         chk("stb_chain", {8'h00, stb_out}, {8'h00, chain_stb[b]});
         rd_chk("inst_ev", base + 6'h02, 16'h0002);
         rd_chk("top_ev", base + 6'h04, 16'h2000);
         cond_set(base, 16'h0000);
         bus_wr(sest_pkg::A_CMD, 16'h0001);
         wait_n(3);
         chk("stb_cls", {8'h00, stb_out}, 16'h0000);
         rd_chk("sum_cls", base, 16'h0000);
         rd_chk("en_kept", base + 6'h05, 16'h2000);
         bus_wr(base + 6'h01, 16'h0000);
         bus_wr(base + 6'h03, 16'h0000);
         bus_wr(base + 6'h05, 16'h0000);
      end
      // Error queue and interrupt
      bus_wr(sest_pkg::A_IRQ_EN, 16'h0002);
      push(1);
      wait_n(3);
      chk("irq_err", {15'h0000, irq_out}, 16'h0001);
      chk("stb_err", {8'h00, stb_out}, 16'h0004);
      rd_chk("err_cnt", sest_pkg::A_ERR_CNT, 16'h0001);
      bus_wr(sest_pkg::A_IRQ_EN, 16'h0000);
      wait_n(2);
      chk("irq_mask", {15'h0000, irq_out}, 16'h0000);
      rd_chk("irq_stat", sest_pkg::A_IRQ_STAT, 16'h0002);
      bus_wr(sest_pkg::A_IRQ_CLR, 16'h0002);
      rd_chk("irq_clr", sest_pkg::A_IRQ_STAT, 16'h0000);
      push(4);
      rd_chk("err_full", sest_pkg::A_ERR_CNT, 16'h0004);
      bus_wr(sest_pkg::A_SRE, 16'h0004);
      wait_n(3);
      chk("stb_rqs", {8'h00, stb_out}, 16'h0044);
      rd_chk("irq_ovf", sest_pkg::A_IRQ_STAT, 16'h0005);
      bus_wr(sest_pkg::A_IRQ_EN, 16'h0007);
      wait_n(2);
      chk("irq_on", {15'h0000, irq_out}, 16'h0001);
      bus_wr(sest_pkg::A_IRQ_CLR, 16'h0007);
      wait_n(2);
      chk("irq_off", {15'h0000, irq_out}, 16'h0000);
      bus_wr(sest_pkg::A_CMD, 16'h0002);
      rd_chk("err_pop", sest_pkg::A_ERR_CNT, 16'h0003);
      bus_wr(sest_pkg::A_CMD, 16'h0001);
      wait_n(3);
      chk("stb_eq_cls", {8'h00, stb_out}, 16'h0000);
      rd_chk("err_cls", sest_pkg::A_ERR_CNT, 16'h0000);
      rd_chk("sre_kept", sest_pkg::A_SRE, 16'h0004);
      bus_wr(sest_pkg::A_SRE, 16'h0000);
      rd_chk("sre_zero", sest_pkg::A_SRE, 16'h0000);
      bus_wr(sest_pkg::A_IRQ_EN, 16'h0000);
      // Reply waiting
      @(posedge clk_in);
      reply_waiting_in <= 1'b1;
      bus_wr(sest_pkg::A_SRE, 16'h0010);
      wait_n(3);
      chk("stb_reply", {8'h00, stb_out}, 16'h0050);
      @(posedge clk_in);
      reply_waiting_in <= 1'b0;
      wait_n(3);
      chk("stb_noreply", {8'h00, stb_out}, 16'h0000);
      // Whole word writes, widths and read-only places
      bus_wr(sest_pkg::A_ESE, 16'hFFFF);
      rd_chk("ese_w", sest_pkg::A_ESE, 16'h00FF);
      bus_wr(sest_pkg::A_ESE, 16'h0004);
      rd_chk("ese_word", sest_pkg::A_ESE, 16'h0004);
      bus_wr(6'h21, 16'hFFFF);
      rd_chk("br_w", 6'h21, 16'hFFFF);
      bus_wr(6'h21, 16'h0000);
      rd_chk("br_zero", 6'h21, 16'h0000);
      bus_wr(sest_pkg::A_STB, 16'hFFFF);
      bus_wr(sest_pkg::A_ERR_CNT, 16'h0003);
      rd_chk("stb_ro", sest_pkg::A_STB, 16'h0000);
      rd_chk("cnt_ro", sest_pkg::A_ERR_CNT, 16'h0000);
      // Second reset with state held
      bus_wr(sest_pkg::A_SRE, 16'h00FF);
      push(1);
      cond_set(sest_pkg::A_ESR, 16'h0001);
      wait_n(3);
      std_event_in <= 8'h00;
      do_reset();
      chk("stb_rst", {8'h00, stb_out}, 16'h0000);
      rd_chk("sre_rst", sest_pkg::A_SRE, 16'h0000);
      rd_chk("ese_rst", sest_pkg::A_ESE, 16'h0000);
      rd_chk("esr_rst", sest_pkg::A_ESR, 16'h0000);
      rd_chk("cnt_rst", sest_pkg::A_ERR_CNT, 16'h0000);
      summarize();
   end
endmodule
